// ===== core/cpst_host.sv
// Host controller: Wishbone command port and built-in capture self-test sequencer
//
// Implementation choice: register access over Wishbone.
`timescale 1ns/1ps
`default_nettype none
module cpst_host
    import cpst_pkg::*;
(
    input  wire logic                  ref_clk,
    input  wire logic                  rstn,
    input  wire logic                  wb_cyc_i,
    input  wire logic                  wb_stb_i,
    input  wire logic                  wb_we_i,
    input  wire logic [WB_ADR_W-1:0]   wb_adr_i,
    input  wire logic [3:0]            wb_sel_i,
    input  wire logic [31:0]           wb_dat_i,
    output var  logic [31:0]           wb_dat_o,
    output var  logic                  wb_ack_o,
    cpst_if.host                       ifc
);
    import cpst_pkg::*;

    typedef struct packed {
        cpst_op_t          op;
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] data;
    } cpst_step_t;

    typedef enum logic [1:0] {H_IDLE, H_ISSUE, H_WAIT_READ, H_NEXT} cpst_state_t;

    // Zeros pass at full threshold first, then ones at the low limit
    function automatic cpst_step_t step_rom(input logic [4:0] i, input logic pass);
        logic [DATA_W-1:0] th;
        th = pass ? THRESH_MIN : THRESH_MAX;
        unique case (i)
            5'd0:  return '{OP_WRITE, PORT_LOGIN_CTL, VAL_LOGIN_DEMUX};
            5'd1:  return '{OP_WRITE, PORT_MEM_CTL, VAL_MEM_LOAD};
            5'd2:  return '{OP_PC0, PORT_MEM_CTL, VAL_CLK_GATE};
            5'd3:  return '{OP_PC15, PORT_MEM_CTL, VAL_STEP_SEL};
            5'd4:  return '{OP_LOAD, PORT_MEM_CTL, VAL_ZERO};
            5'd5:  return '{OP_WRITE, PORT_WRITE_CTL, VAL_WR_ON};
            5'd6:  return '{OP_WRITE, PORT_MEM_CTL, VAL_MEM_HOLD};
            5'd7:  return '{OP_THRESH, PORT_MEM_CTL, th};
            5'd8:  return '{OP_CLK_INIT, PORT_MEM_CTL, VAL_ZERO};
            5'd9:  return '{OP_EXT_STEP, PORT_MEM_CTL, VAL_ZERO};
            5'd10, 5'd11, 5'd12:
                   return '{OP_STEP, PORT_MEM_CTL, VAL_ZERO};
            5'd13: return '{OP_WRITE, PORT_WRITE_CTL, VAL_WR_OFF};
            5'd14: return '{OP_WRITE, PORT_MEM_CTL, VAL_MEM_READ};
            5'd15: return '{OP_READ, PORT_POD_A, VAL_ZERO};
            5'd16: return '{OP_READ, PORT_POD_B, VAL_ZERO};
            5'd17: return '{OP_READ, PORT_POD_C, VAL_ZERO};
            default: return '{OP_READ, PORT_POD_C, VAL_ZERO};
        endcase
    endfunction

    cpst_state_t       state;
    cpst_step_t        cur;
    logic              seq_mode;
    logic              pass;
    logic [4:0]        seq_idx;
    logic              done;
    logic              fail;
    logic [DATA_W-1:0] last_rdata;

    wire wb_hit    = wb_cyc_i && wb_stb_i && wb_ack_o;
    wire wr_cmd    = wb_hit && wb_we_i && (wb_adr_i == WB_REG_CMD) && (&wb_sel_i[2:0]);
    wire wr_ctrl   = wb_hit && wb_we_i && (wb_adr_i == WB_REG_CTRL) && wb_sel_i[0];
    wire busy      = (state != H_IDLE);
    wire start_seq = wr_ctrl && wb_dat_i[CTRL_START_BIT] && !busy;
    wire start_cmd = wr_cmd && !busy;
    wire issuing   = (state == H_ISSUE);
    wire [DATA_W-1:0] expect_val = pass ? VAL_ONES : VAL_ZERO;
    wire seq_end   = (seq_idx == SEQ_LAST);

    wire [31:0] status_word = {8'h00, 3'b000, seq_idx, last_rdata, 5'b00000,
                               fail, done, busy};
    wire [31:0] next_dat = (wb_adr_i == WB_REG_STATUS) ? status_word : 32'h0000_0000;

    // Wishbone classic slave: ack one cycle after the strobe, dropped after one cycle
    always_ff @(posedge ref_clk) begin
        if (!rstn) begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= '0;
        end else begin
            wb_ack_o <= wb_cyc_i && wb_stb_i && !wb_ack_o;
            wb_dat_o <= next_dat;
        end
    end

    // Operation sequencer; a command while busy is dropped
    always_ff @(posedge ref_clk) begin
        if (!rstn) begin
            state      <= H_IDLE;
            cur        <= '{OP_READ, PORT_POD_A, VAL_ZERO};
            seq_mode   <= 1'b0;
            pass       <= 1'b0;
            seq_idx    <= '0;
            done       <= 1'b0;
            fail       <= 1'b0;
            last_rdata <= '0;
        end else begin
            unique case (state)
                H_IDLE: begin
                    if (start_seq) begin
                        seq_mode <= 1'b1;
                        pass     <= 1'b0;
                        seq_idx  <= '0;
                        done     <= 1'b0;
                        fail     <= 1'b0;
                        cur      <= step_rom(5'd0, 1'b0);
                        state    <= H_ISSUE;
                    end else if (start_cmd) begin
                        seq_mode <= 1'b0;
                        cur      <= '{cpst_op_t'(wb_dat_i[CMD_OP_LSB +: 4]),
                                      wb_dat_i[CMD_ADDR_LSB +: ADDR_W],
                                      wb_dat_i[CMD_DATA_LSB +: DATA_W]};
                        state    <= H_ISSUE;
                    end
                end
                H_ISSUE: begin
                    state <= (cur.op == OP_READ) ? H_WAIT_READ : H_NEXT;
                end
                H_WAIT_READ: begin
                    if (ifc.port_rvalid) begin
                        last_rdata <= ifc.port_rdata;
                        if (seq_mode && (ifc.port_rdata != expect_val)) begin
                            fail  <= 1'b1;
                            done  <= 1'b1;
                            state <= H_IDLE;
                        end else begin
                            state <= H_NEXT;
                        end
                    end
                end
                H_NEXT: begin
                    if (!seq_mode) begin
                        state <= H_IDLE;
                    end else if (seq_end && pass) begin
                        done  <= 1'b1;
                        state <= H_IDLE;
                    end else if (seq_end) begin
                        pass    <= 1'b1;
                        seq_idx <= SEQ_PASS2;
                        cur     <= step_rom(SEQ_PASS2, 1'b1);
                        state   <= H_ISSUE;
                    end else begin
                        seq_idx <= seq_idx + 5'd1;
                        cur     <= step_rom(seq_idx + 5'd1, pass);
                        state   <= H_ISSUE;
                    end
                end
            endcase
        end
    end

    // Link strobes are one-cycle pulses in the cycle after H_ISSUE
    always_ff @(posedge ref_clk) begin
        if (!rstn) begin
            ifc.port_addr            <= '0;
            ifc.port_wdata           <= '0;
            ifc.port_wr              <= 1'b0;
            ifc.port_rd              <= 1'b0;
            ifc.threshold_stb        <= 1'b0;
            ifc.single_step_stb      <= 1'b0;
            ifc.ext_step_stb         <= 1'b0;
            ifc.port_ctl_zero        <= 1'b0;
            ifc.port_ctl_one_to_five <= '0;
            ifc.clk_init_wr          <= 1'b0;
            ifc.addr_load            <= 1'b0;
        end else begin
            if (issuing) begin
                ifc.port_addr  <= cur.addr;
                ifc.port_wdata <= cur.data;
            end
            ifc.port_wr              <= issuing && (cur.op == OP_WRITE);
            ifc.port_rd              <= issuing && (cur.op == OP_READ);
            ifc.threshold_stb        <= issuing && (cur.op == OP_THRESH);
            ifc.single_step_stb      <= issuing && (cur.op == OP_STEP);
            ifc.ext_step_stb         <= issuing && (cur.op == OP_EXT_STEP);
            ifc.port_ctl_zero        <= issuing && (cur.op == OP_PC0);
            ifc.port_ctl_one_to_five <= {5{issuing && (cur.op == OP_PC15)}};
            ifc.clk_init_wr          <= issuing && (cur.op == OP_CLK_INIT);
            ifc.addr_load            <= issuing && (cur.op == OP_LOAD);
        end
    end
endmodule
`default_nettype wire

// ===== core/cpst_pkg.sv
// Shared constants and types for the capture path self-test control port
package cpst_pkg;
    localparam int DATA_W = 8;
    localparam int ADDR_W = 5;
    localparam int POD_N  = 3;
    localparam int MAR_W  = 10;
    localparam int MEM_DEPTH = 1 << MAR_W;

    // Device port map, read and write sides are separate decodes
    localparam logic [ADDR_W-1:0] PORT_MEM_CTL   = 5'h03;
    localparam logic [ADDR_W-1:0] PORT_LOGIN_CTL = 5'h0c;
    localparam logic [ADDR_W-1:0] PORT_WRITE_CTL = 5'h1b;
    localparam logic [ADDR_W-1:0] PORT_MAR_LO    = 5'h03;
    localparam logic [ADDR_W-1:0] PORT_MAR_HI    = 5'h04;
    localparam logic [ADDR_W-1:0] PORT_POD_A     = 5'h0b;
    localparam logic [ADDR_W-1:0] PORT_POD_B     = 5'h0c;
    localparam logic [ADDR_W-1:0] PORT_POD_C     = 5'h0d;

    // Field positions
    localparam int LOGIN_DEMUX_BIT    = 4;
    localparam int LOGIN_PROBE_EN_LSB = 5;
    localparam int MEM_READ_SEL_BIT   = 0;
    localparam int MEM_COUNT_EN_N_BIT = 4;
    localparam int MEM_RDBK_GATE_BIT  = 5;
    localparam int CLK_SEL_DATA_BIT   = 7;

    // Reset values
    localparam logic [DATA_W-1:0] LOGIN_CTL_RST = 8'h00;
    localparam logic [DATA_W-1:0] MEM_CTL_RST   = 8'h10;
    localparam logic [DATA_W-1:0] WRITE_CTL_RST = 8'hff;
    localparam logic [DATA_W-1:0] THRESH_RST    = 8'h80;

    // Data values used by the self-test
    localparam logic [DATA_W-1:0] THRESH_MAX     = 8'hff;
    localparam logic [DATA_W-1:0] THRESH_MIN     = 8'h00;
    localparam logic [DATA_W-1:0] VAL_LOGIN_DEMUX = 8'hfb;
    localparam logic [DATA_W-1:0] VAL_MEM_LOAD   = 8'h20;
    localparam logic [DATA_W-1:0] VAL_MEM_HOLD   = 8'h10;
    localparam logic [DATA_W-1:0] VAL_WR_ON      = 8'h18;
    localparam logic [DATA_W-1:0] VAL_WR_OFF     = 8'h1f;
    localparam logic [DATA_W-1:0] VAL_MEM_READ   = 8'h31;
    localparam logic [DATA_W-1:0] VAL_CLK_GATE   = 8'h7f;
    localparam logic [DATA_W-1:0] VAL_STEP_SEL   = 8'h80;
    localparam logic [DATA_W-1:0] VAL_ZERO       = 8'h00;
    localparam logic [DATA_W-1:0] VAL_ONES       = 8'hff;

    // Host operations
    typedef enum logic [3:0] {
        OP_WRITE, OP_READ, OP_THRESH, OP_STEP, OP_EXT_STEP,
        OP_PC0, OP_PC15, OP_CLK_INIT, OP_LOAD
    } cpst_op_t;

    // Host Wishbone register map (byte addresses)
    localparam int WB_ADR_W = 4;
    localparam logic [WB_ADR_W-1:0] WB_REG_CMD    = 4'h0;
    localparam logic [WB_ADR_W-1:0] WB_REG_STATUS = 4'h4;
    localparam logic [WB_ADR_W-1:0] WB_REG_CTRL   = 4'h8;
    localparam int CMD_DATA_LSB = 0;
    localparam int CMD_ADDR_LSB = 8;
    localparam int CMD_OP_LSB   = 16;
    localparam int ST_BUSY_BIT  = 0;
    localparam int ST_DONE_BIT  = 1;
    localparam int ST_FAIL_BIT  = 2;
    localparam int ST_RDATA_LSB = 8;
    localparam int ST_STEP_LSB  = 16;
    localparam int CTRL_START_BIT = 0;

    // Self-test sequence shape
    localparam logic [4:0] SEQ_LAST   = 5'd17;
    localparam logic [4:0] SEQ_PASS2  = 5'd5;
    localparam logic [4:0] SEQ_FIRST_READ = 5'd15;
endpackage

// ===== core/cpst_if.sv
// Interface between the host controller and the acquisition control port
`timescale 1ns/1ps
`default_nettype none
interface cpst_if;
    import cpst_pkg::*;
    logic [ADDR_W-1:0] port_addr;
    logic [DATA_W-1:0] port_wdata;
    logic              port_wr;
    logic              port_rd;
    logic [DATA_W-1:0] port_rdata;
    logic              port_rvalid;
    logic              threshold_stb;
    logic              single_step_stb;
    logic              ext_step_stb;
    logic              port_ctl_zero;
    logic [4:0]        port_ctl_one_to_five;
    logic              clk_init_wr;
    logic              addr_load;

    modport device (
        input  port_addr, port_wdata, port_wr, port_rd, threshold_stb, single_step_stb,
               ext_step_stb, port_ctl_zero, port_ctl_one_to_five, clk_init_wr, addr_load,
        output port_rdata, port_rvalid
    );
    modport host (
        output port_addr, port_wdata, port_wr, port_rd, threshold_stb, single_step_stb,
               ext_step_stb, port_ctl_zero, port_ctl_one_to_five, clk_init_wr, addr_load,
        input  port_rdata, port_rvalid
    );
endinterface
`default_nettype wire

// ===== core/cpst_device.sv
// Acquisition module control port: latches, clock path, capture memory, readback
// Contract
// - FB to login latch selects probe demux login
// - 20 to memory latch permits address load
// - Load address zero, 18 enables all writes
// - 10 to memory latch holds address counter
// - FF threshold makes every probe read low
// - Clock-init zero clears every clock flip-flop
// - Three single steps store login data
// - 1F to write latch ends memory writes
// - 31 to memory latch selects capture readback
// - Pods read back at ports 0B-0D
// - 7F with line zero opens clock gate
// - 80 with lines one-five selects step clock
// - Host checks zeros, then ones, in sequence
// - Write latch bits 0-2 are write enables
// - Login latch bit 4 is demux select
`timescale 1ns/1ps
`default_nettype none
module cpst_device
    import cpst_pkg::*;
(
    input  wire logic                     ref_clk,
    input  wire logic                     rstn,
    cpst_if.device                        ifc,
    input  wire logic [POD_N-1:0][7:0]    probe_pins,
    output var  logic                     demux_capture_select,
    output var  logic                     memory_readback_gate,
    output var  logic                     address_count_enable_n,
    output var  logic [POD_N-1:0]         capture_write_enables_n,
    output var  logic                     capture_read_select,
    output var  logic                     clock_gate_control,
    output var  logic                     step_clock_select,
    output var  logic [MAR_W-1:0]         sample_address_counter,
    output var  logic [DATA_W-1:0]        threshold_level
);
    import cpst_pkg::*;

    function automatic logic is_pod_port(input logic [ADDR_W-1:0] a);
        return (a == PORT_POD_A) || (a == PORT_POD_B) || (a == PORT_POD_C);
    endfunction

    function automatic logic [1:0] pod_of_port(input logic [ADDR_W-1:0] a);
        logic [ADDR_W-1:0] d;
        d = a - PORT_POD_A;
        return d[1:0];
    endfunction

    logic [DATA_W-1:0]      login_control_latch;
    logic [DATA_W-1:0]      memory_control_latch;
    logic [DATA_W-1:0]      write_control_latch;
    logic [POD_N-1:0]       clk_gen_ff;
    logic [7:0]             login_reg [POD_N];
    logic [7:0]             mem_q [POD_N];
    logic [DATA_W-1:0]      rdata;
    logic                   rvalid;

    // Write decode
    wire wr_login = ifc.port_wr && (ifc.port_addr == PORT_LOGIN_CTL);
    wire wr_mem   = ifc.port_wr && (ifc.port_addr == PORT_MEM_CTL);
    wire wr_write = ifc.port_wr && (ifc.port_addr == PORT_WRITE_CTL);

    // Control outputs taken straight from the latch flip-flops
    assign demux_capture_select    = login_control_latch[LOGIN_DEMUX_BIT];
    assign memory_readback_gate    = memory_control_latch[MEM_RDBK_GATE_BIT];
    assign address_count_enable_n  = memory_control_latch[MEM_COUNT_EN_N_BIT];
    assign capture_read_select     = memory_control_latch[MEM_READ_SEL_BIT];
    assign capture_write_enables_n = write_control_latch[POD_N-1:0];

    wire [POD_N-1:0] probe_login_en =
        login_control_latch[LOGIN_PROBE_EN_LSB +: POD_N];

    // Threshold extremes force every input one way; between them pins pass
    wire thresh_all_low  = (threshold_level == THRESH_MAX);
    wire thresh_all_high = (threshold_level == THRESH_MIN);

    // Any set clock flip-flop blocks the external step clock
    wire step_path_open  = !clock_gate_control && step_clock_select
                           && (clk_gen_ff == '0);
    wire login_clk       = ifc.ext_step_stb && step_path_open;
    wire master_clk      = ifc.single_step_stb;
    wire read_pod        = ifc.port_rd && is_pod_port(ifc.port_addr);
    wire [1:0] rd_pod    = pod_of_port(ifc.port_addr);

    // Pod readback: memory once read select is up, else the login register
    wire [7:0] pod_read_val = capture_read_select ? mem_q[rd_pod]
                                                  : login_reg[rd_pod];

    wire [DATA_W-1:0] mar_hi_val = {{(DATA_W-(MAR_W-DATA_W)){1'b0}},
                                    sample_address_counter[MAR_W-1:DATA_W]};

    wire [DATA_W-1:0] next_rdata =
        read_pod                                                ? pod_read_val :
        (ifc.port_rd && (ifc.port_addr == PORT_MAR_LO))         ?
            sample_address_counter[DATA_W-1:0] :
        (ifc.port_rd && (ifc.port_addr == PORT_MAR_HI))         ? mar_hi_val :
        '0;

    // Control latches hold the full byte until the next write to the port
    always_ff @(posedge ref_clk) begin
        if (!rstn) begin
            login_control_latch  <= LOGIN_CTL_RST;
            memory_control_latch <= MEM_CTL_RST;
            write_control_latch  <= WRITE_CTL_RST;
        end else begin
            if (wr_login) begin
                login_control_latch <= ifc.port_wdata;
            end
            if (wr_mem) begin
                memory_control_latch <= ifc.port_wdata;
            end
            if (wr_write) begin
                write_control_latch <= ifc.port_wdata;
            end
        end
    end

    // Threshold and clock source selection
    always_ff @(posedge ref_clk) begin
        if (!rstn) begin
            threshold_level    <= THRESH_RST;
            clock_gate_control <= 1'b1;
            step_clock_select  <= 1'b0;
        end else begin
            if (ifc.threshold_stb) begin
                threshold_level <= ifc.port_wdata;
            end
            if (ifc.port_ctl_zero) begin
                clock_gate_control <= ifc.port_wdata[CLK_SEL_DATA_BIT];
            end
            if (ifc.port_ctl_one_to_five != '0) begin
                step_clock_select <= ifc.port_wdata[CLK_SEL_DATA_BIT];
            end
        end
    end

    // A threshold swing can clock these; set wins over a same-cycle clear
    always_ff @(posedge ref_clk) begin
        if (!rstn) begin
            clk_gen_ff <= '0;
        end else if (ifc.threshold_stb) begin
            clk_gen_ff <= '1;
        end else if (ifc.clk_init_wr && (ifc.port_wdata == VAL_ZERO)) begin
            clk_gen_ff <= '0;
        end
    end

    // Sample address counter: loads only while counting is enabled
    always_ff @(posedge ref_clk) begin
        if (!rstn) begin
            sample_address_counter <= '0;
        end else if (!address_count_enable_n) begin
            if (ifc.addr_load) begin
                sample_address_counter <= MAR_W'(ifc.port_wdata);
            end else if (master_clk) begin
                sample_address_counter <= sample_address_counter + 1'b1;
            end
        end
    end

    // Per-pod input conditioning, login register and capture memory
    for (genvar p = 0; p < POD_N; p++) begin : g_pod
        logic [7:0] probe_s1;
        logic [7:0] probe_s2;
        logic [7:0] probe_s3;
        logic [7:0] probe_filt;
        logic [7:0] capture_mem [MEM_DEPTH];
        wire  [7:0] probe_seen = thresh_all_low  ? 8'h00 :
                                 thresh_all_high ? 8'hff : probe_filt;

        always_ff @(posedge ref_clk) begin
            if (!rstn) begin
                probe_s1   <= '0;
                probe_s2   <= '0;
                probe_s3   <= '0;
                probe_filt <= '0;
            end else begin
                probe_s1   <= probe_pins[p];
                probe_s2   <= probe_s1;
                probe_s3   <= probe_s2;
                probe_filt <= (probe_s2 & probe_s3)
                              | (probe_filt & ~(probe_s2 ^ probe_s3));
            end
        end

        always_ff @(posedge ref_clk) begin
            if (!rstn) begin
                login_reg[p] <= '0;
            end else if (login_clk && probe_login_en[p]) begin
                login_reg[p] <= probe_seen;
            end
        end

        // Memory has no reset; contents are only meaningful once written
        always_ff @(posedge ref_clk) begin
            if (master_clk && !capture_write_enables_n[p]) begin
                capture_mem[sample_address_counter] <= login_reg[p];
            end
        end

        always_ff @(posedge ref_clk) begin
            mem_q[p] <= capture_mem[sample_address_counter];
        end
    end

    // Read answer one cycle after the strobe
    always_ff @(posedge ref_clk) begin
        if (!rstn) begin
            rdata  <= '0;
            rvalid <= 1'b0;
        end else begin
            rvalid <= ifc.port_rd;
            if (ifc.port_rd) begin
                rdata <= next_rdata;
            end
        end
    end

    assign ifc.port_rdata  = rdata;
    assign ifc.port_rvalid = rvalid;
endmodule
`default_nettype wire

// ===== testbench/cpst_monitor.sv
// Link and latch checks for the capture control port
`timescale 1ns/1ps
`default_nettype none
module cpst_monitor (
    input wire logic       ref_clk,
    input wire logic       rstn,
    input wire logic       port_wr,
    input wire logic       port_rd,
    input wire logic       port_rvalid,
    input wire logic [4:0] port_addr,
    input wire logic [7:0] port_wdata,
    input wire logic [2:0] capture_write_enables_n,
    input wire logic       demux_capture_select,
    input wire logic       capture_read_select
);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!rstn);
    wire logic wr_w = port_wr && port_addr == 5'h1b;
    wire logic wr_m = port_wr && port_addr == 5'h03;
    property p_rv; port_rd |=> port_rvalid; endproperty
    a_rv: assert property (p_rv) else $error("read answer late");
    property p_rv1; port_rvalid |=> !port_rvalid; endproperty
    a_rv1: assert property (p_rv1) else $error("read answer long");
    property p_we; wr_w |=> capture_write_enables_n == $past(port_wdata[2:0]); endproperty
    a_we: assert property (p_we) else $error("write enables wrong");
    property p_weh; !wr_w |=> $stable(capture_write_enables_n); endproperty
    a_weh: assert property (p_weh) else $error("write latch moved");
    property p_dm; port_wr && port_addr == 5'h0c |=> demux_capture_select == $past(port_wdata[4]);
    endproperty
    a_dm: assert property (p_dm) else $error("demux select wrong");
    property p_rs; wr_m |=> capture_read_select == $past(port_wdata[0]); endproperty
    a_rs: assert property (p_rs) else $error("read select wrong");
    property p_rsh; !wr_m |=> $stable(capture_read_select); endproperty
    a_rsh: assert property (p_rsh) else $error("memory latch moved");
    property p_sp; port_wr |=> !port_wr; endproperty
    a_sp: assert property (p_sp) else $error("writes too close");
endmodule
`default_nettype wire

// ===== testbench/capture_path_selftest_control_test.sv
// Bench: host and control port joined, driven over Wishbone
`timescale 1ns/1ps
`default_nettype none
module capture_path_selftest_control_test;
    import cpst_pkg::*;
    localparam logic [2:0][7:0] PINS = 24'h5a3cc3;
    logic        ref_clk = '0, rstn = '0, cyc = '0, stb = '0, we = '0;
    logic [3:0]  adr = '0;
    logic [31:0] wdat = '0, rdat, s;
    logic        ack, dmx, gate, cen_n, rsel, cgc, ssel;
    logic [2:0]  wen_n;
    logic [9:0]  cnt;
    logic [7:0]  thr;
    int          n_mismatch = 0, n_checks = 0;
    wire logic [8:0] ctl = {dmx, gate, cen_n, wen_n, rsel, cgc, ssel};
    cpst_if ifc ();
    cpst_host u_cpst_host (.ref_clk, .rstn, .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
        .wb_adr_i(adr), .wb_sel_i(4'hf), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
        .ifc(ifc.host));
    cpst_device u_cpst_device (.ref_clk, .rstn, .ifc(ifc.device), .probe_pins(PINS),
        .demux_capture_select(dmx), .memory_readback_gate(gate), .address_count_enable_n(cen_n),
        .capture_write_enables_n(wen_n), .capture_read_select(rsel), .clock_gate_control(cgc),
        .step_clock_select(ssel), .sample_address_counter(cnt), .threshold_level(thr));
    cpst_monitor u_cpst_monitor (.ref_clk, .rstn, .port_wr(ifc.port_wr), .port_rd(ifc.port_rd),
        .port_rvalid(ifc.port_rvalid), .port_addr(ifc.port_addr), .port_wdata(ifc.port_wdata),
        .capture_write_enables_n(wen_n), .demux_capture_select(dmx), .capture_read_select(rsel));
    task automatic chk(input logic [31:0] v, e);
        n_checks++;
        if (v !== e) begin
            n_mismatch++;
            $display("BAD %0t seen %h expected %h", $time, v, e);
        end
    endtask
    task automatic wb(input logic w, input logic [3:0] a, input logic [31:0] d);
        cyc <= 1'h1;
        stb <= 1'h1;
        we <= w;
        adr <= a;
        wdat <= d;
        do @(posedge ref_clk); while (ack !== 1'h1);
        s = rdat;
        cyc <= 1'h0;
        stb <= 1'h0;
        @(posedge ref_clk);
    endtask
    task automatic cmd(input cpst_op_t op, input logic [4:0] a, input logic [7:0] d);
        wb(1'h1, WB_REG_CMD, {12'h000, op, 3'h0, a, d});
        do wb(1'h0, WB_REG_STATUS, '0); while (s[ST_BUSY_BIT] !== 1'h0);
    endtask
    task automatic finish_test;
        $display("checks %0d mismatches %0d", n_checks, n_mismatch);
        if (n_mismatch == 0 && n_checks > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    initial forever #10 ref_clk = ~ref_clk;
    initial begin
        #400us;
        n_mismatch++;
        finish_test();
    end
    initial begin
        repeat (8) @(posedge ref_clk);
        rstn <= 1'h1;
        @(posedge ref_clk);
        chk({15'h0, thr, ctl}, 32'h1007a);
        cmd(OP_WRITE, PORT_LOGIN_CTL, VAL_LOGIN_DEMUX);
        chk({23'h0, ctl}, 32'h17a);
        cmd(OP_WRITE, PORT_MEM_CTL, VAL_MEM_LOAD);
        chk({23'h0, ctl}, 32'h1ba);
        cmd(OP_PC0, 5'h00, VAL_CLK_GATE);
        chk({23'h0, ctl}, 32'h1b8);
        cmd(OP_PC15, 5'h00, VAL_STEP_SEL);
        chk({23'h0, ctl}, 32'h1b9);
        for (int p = 0; p < 2; p++) begin
            cmd(OP_LOAD, 5'h00, VAL_ZERO);
            cmd(OP_WRITE, PORT_WRITE_CTL, VAL_WR_ON);
            cmd(OP_WRITE, PORT_MEM_CTL, VAL_MEM_HOLD);
            chk({13'h0, cnt, ctl}, 32'h141);
            cmd(OP_THRESH, 5'h00, p ? THRESH_MIN : THRESH_MAX);
            chk({24'h0, thr}, p ? 32'h0 : 32'hff);
            // Skipping the init would leave pass two holding zeros
            cmd(OP_CLK_INIT, 5'h00, VAL_ZERO);
            cmd(OP_EXT_STEP, 5'h00, VAL_ZERO);
            repeat (3) cmd(OP_STEP, 5'h00, VAL_ZERO);
            cmd(OP_WRITE, PORT_WRITE_CTL, VAL_WR_OFF);
            chk({13'h0, cnt, ctl}, 32'h179);
            cmd(OP_WRITE, PORT_MEM_CTL, VAL_MEM_READ);
            chk({23'h0, ctl}, 32'h1fd);
            for (int k = 0; k < 3; k++) begin
                cmd(OP_READ, PORT_POD_A + 5'(k), VAL_ZERO);
                chk({24'h0, s[15:8]}, p ? 32'hff : 32'h0);
            end
            $display("pass %0d done", p);
        end
        // Mid threshold passes the pins, so each pod holds a distinct byte
        cmd(OP_THRESH, 5'h00, 8'h80);
        cmd(OP_CLK_INIT, 5'h00, VAL_ZERO);
        cmd(OP_EXT_STEP, 5'h00, VAL_ZERO);
        cmd(OP_WRITE, PORT_WRITE_CTL, VAL_WR_ON);
        cmd(OP_STEP, 5'h00, VAL_ZERO);
        cmd(OP_WRITE, PORT_WRITE_CTL, VAL_WR_OFF);
        for (int k = 0; k < 3; k++) begin
            cmd(OP_READ, PORT_POD_A + 5'(k), VAL_ZERO);
            chk({24'h0, s[15:8]}, {24'h0, PINS[k]});
        end
        cmd(OP_WRITE, PORT_MEM_CTL, VAL_MEM_LOAD);
        cmd(OP_LOAD, 5'h00, 8'h2a);
        cmd(OP_STEP, 5'h00, VAL_ZERO);
        cmd(OP_READ, PORT_MAR_LO, VAL_ZERO);
        chk({24'h0, s[15:8]}, 32'h2b);
        cmd(OP_WRITE, PORT_MEM_CTL, VAL_MEM_HOLD);
        cmd(OP_LOAD, 5'h00, VAL_ZERO);
        cmd(OP_STEP, 5'h00, VAL_ZERO);
        chk({22'h0, cnt}, 32'h2b);
        $display("pods and counter done");
        wb(1'h0, 4'hc, '0);
        chk(s, 32'h0);
        wb(1'h1, WB_REG_CTRL, 32'h1);
        do wb(1'h0, WB_REG_STATUS, '0); while (s[ST_DONE_BIT] !== 1'h1);
        chk({29'h0, s[2:0]}, 32'h2);
        $display("self-test done");
        finish_test();
    end
endmodule
`default_nettype wire
